/* rtl/shc_pkg.sv */
// Constants and types for the sample-and-hold array sequencer.
// Assumes a 10 MHz clock; the array itself has no clock and decodes pin levels.
// Contract
// - Active levels: line and strap low, choose high.
// - Keep sample mode at least 4 microseconds.
// - Change address only in hold, minimum hold width.
// - Address setup before valid, hold after hold entry.
// - Sixth bit drives choose; strap-high answers lower half.
// - Resample every channel at least every 250ms.
package shc_pkg;
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned NUM_CH = 32;
   localparam int unsigned ADDR_W = 5;
   localparam int unsigned BANK_ADDR_W = 6;
   localparam int unsigned SAMPLE_NS = 4000;
   localparam int unsigned HOLD_PW_NS = 200;
   localparam int unsigned ADDR_SETUP_NS = 200;
   localparam int unsigned ADDR_HOLD_NS = 200;
   localparam int unsigned REFRESH_MS = 250;
   localparam int unsigned SAMPLE_CYC = (SAMPLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned HOLD_PW_CYC = (HOLD_PW_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned SETUP_CYC = (ADDR_SETUP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned AHOLD_CYC = (ADDR_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned REFRESH_CYC = REFRESH_MS * (CLK_HZ / 1000);
   localparam int unsigned CNT_W = 22;
   localparam logic [0:0] SH_HOLD = 1'h1;
   localparam logic [0:0] SH_SAMPLE = 1'h0;

   typedef enum logic [2:0] {ST_IDLE, ST_AHOLD, ST_SETUP, ST_SAMPLE, ST_PW} shc_state_e;

   typedef struct packed {
      logic sample_hold_n;
      logic chip_choose;
      logic polarity_strap;
      logic [ADDR_W-1:0] host_addr_low;
      logic bank_addr_bit;
   } shc_pins_s;
endpackage : shc_pkg

/* rtl/shc_ctrl.sv */
// Host-side sequencer for one or two 32-channel sample-and-hold arrays.
// Assumes request inputs come from logic on CLK_IN; pins go straight to the array(s).
`timescale 1ns/100ps
`default_nettype none
module shc_ctrl #(
   parameter int unsigned REFRESH_CYC = shc_pkg::REFRESH_CYC
) (
   // Clock and reset
   input wire logic CLK_IN,
   input wire logic NRST_IN,
   // Request side
   input wire logic REQ_VALID_IN,
   input wire logic [shc_pkg::BANK_ADDR_W-1:0] REQ_CHAN_IN,
   output logic REQ_READY_OUT,
   output logic DONE_OUT,
   output logic REFRESH_DUE_OUT,
   // Array pins
   output shc_pkg::shc_pins_s PINS_OUT
);
   // Sequencer state
   shc_pkg::shc_state_e state_q;
   shc_pkg::shc_state_e state_d;
   logic [shc_pkg::CNT_W-1:0] cnt_q;
   logic [shc_pkg::CNT_W-1:0] cnt_d;
   // Latched channel and sample/hold drive
   logic [shc_pkg::BANK_ADDR_W-1:0] addr_q;
   logic [shc_pkg::BANK_ADDR_W-1:0] addr_d;
   logic sh_q;
   logic sh_d;
   // Completion pulse and refresh deadline
   logic done_q;
   logic done_d;
   logic [shc_pkg::CNT_W-1:0] ref_q;
   logic [shc_pkg::CNT_W-1:0] ref_d;
   logic due_q;
   logic due_d;
   // Decoded events
   logic take;
   logic [shc_pkg::CNT_W-1:0] phase_last;
   logic phase_end;
   logic cycle_end;
   logic sweep_end;
   logic ref_wrap;

   // Requests are taken only in idle, so the address never moves mid-sample
   assign take = REQ_VALID_IN && (state_q == shc_pkg::ST_IDLE);
   assign phase_end = (state_q != shc_pkg::ST_IDLE) && (cnt_q == phase_last);
   assign cycle_end = (state_q == shc_pkg::ST_PW) && phase_end;
   assign sweep_end = cycle_end && (addr_q == '1);
   assign ref_wrap = (ref_q == shc_pkg::CNT_W'(REFRESH_CYC - 1));

   // Last count of each timed phase
   always_comb
   begin
      phase_last = '0;
      unique case (state_q)
         shc_pkg::ST_IDLE:
         begin
            phase_last = '0;
         end
         shc_pkg::ST_SETUP:
         begin
            phase_last = shc_pkg::CNT_W'(shc_pkg::SETUP_CYC - 1);
         end
         shc_pkg::ST_SAMPLE:
         begin
            phase_last = shc_pkg::CNT_W'(shc_pkg::SAMPLE_CYC - 1);
         end
         shc_pkg::ST_AHOLD:
         begin
            phase_last = shc_pkg::CNT_W'(shc_pkg::AHOLD_CYC - 1);
         end
         shc_pkg::ST_PW:
         begin
            phase_last = shc_pkg::CNT_W'(shc_pkg::HOLD_PW_CYC - 1);
         end
         default:
         begin
            phase_last = '0;
         end
      endcase
   end

   // Setup, sample, address hold, hold pulse, then idle again
   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q + 1'b1;
      if (phase_end)
      begin
         cnt_d = '0;
      end
      unique case (state_q)
         shc_pkg::ST_IDLE:
         begin
            cnt_d = '0;
            if (take)
            begin
               state_d = shc_pkg::ST_SETUP;
            end
         end
         shc_pkg::ST_SETUP:
         begin
            if (phase_end)
            begin
               state_d = shc_pkg::ST_SAMPLE;
            end
         end
         shc_pkg::ST_SAMPLE:
         begin
            if (phase_end)
            begin
               state_d = shc_pkg::ST_AHOLD;
            end
         end
         shc_pkg::ST_AHOLD:
         begin
            if (phase_end)
            begin
               state_d = shc_pkg::ST_PW;
            end
         end
         shc_pkg::ST_PW:
         begin
            if (phase_end)
            begin
               state_d = shc_pkg::ST_IDLE;
            end
         end
         default:
         begin
            // An impossible code falls back to idle with every channel held
            state_d = shc_pkg::ST_IDLE;
            cnt_d = '0;
         end
      endcase
   end

   always_ff @(posedge CLK_IN)
   begin
      if (!NRST_IN)
      begin
         state_q <= shc_pkg::ST_IDLE;
         cnt_q <= '0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   always_comb
   begin
      addr_d = addr_q;
      if (take)
      begin
         addr_d = REQ_CHAN_IN;
      end
   end

   always_ff @(posedge CLK_IN)
   begin
      if (!NRST_IN)
      begin
         addr_q <= '0;
      end
      else
      begin
         addr_q <= addr_d;
      end
   end

   // Taken from the next state so the line and the phase flip on one edge
   always_comb
   begin
      sh_d = (state_d == shc_pkg::ST_SAMPLE) ? shc_pkg::SH_SAMPLE : shc_pkg::SH_HOLD;
   end

   always_ff @(posedge CLK_IN)
   begin
      if (!NRST_IN)
      begin
         sh_q <= shc_pkg::SH_HOLD;
      end
      else
      begin
         sh_q <= sh_d;
      end
   end

   always_comb
   begin
      done_d = cycle_end;
   end

   always_ff @(posedge CLK_IN)
   begin
      if (!NRST_IN)
      begin
         done_q <= 1'b0;
      end
      else
      begin
         done_q <= done_d;
      end
   end

   always_comb
   begin
      ref_d = ref_q + 1'b1;
      due_d = due_q;
      if (ref_wrap || sweep_end)
      begin
         ref_d = '0;
      end
      // A deadline landing on the sweep end still counts as missed
      if (ref_wrap)
      begin
         due_d = 1'b1;
      end
      else if (sweep_end)
      begin
         due_d = 1'b0;
      end
   end

   always_ff @(posedge CLK_IN)
   begin
      if (!NRST_IN)
      begin
         ref_q <= '0;
         due_q <= 1'b0;
      end
      else
      begin
         ref_q <= ref_d;
         due_q <= due_d;
      end
   end

   assign REQ_READY_OUT = (state_q == shc_pkg::ST_IDLE);
   assign DONE_OUT = done_q;
   assign REFRESH_DUE_OUT = due_q;

   // strap tied low, choose high
   // Bank 0 device strapped high sees choose low as active; bank 1 strapped low sees it high.
   always_comb
   begin
      PINS_OUT.sample_hold_n = sh_q;
      PINS_OUT.chip_choose = addr_q[shc_pkg::BANK_ADDR_W-1];
      PINS_OUT.polarity_strap = 1'b0;
      PINS_OUT.host_addr_low = addr_q[shc_pkg::ADDR_W-1:0];
      PINS_OUT.bank_addr_bit = addr_q[shc_pkg::BANK_ADDR_W-1];
   end
endmodule : shc_ctrl
`default_nettype wire

/* sim/shc_ctrl_assertions.sv */
// Port checker for the array sequencer.
// Bound into every shc_ctrl instance.
`timescale 1ns/100ps
`default_nettype none
module shc_ctrl_chk (
   input wire logic CLK_IN,
   input wire logic NRST_IN,
   input wire logic REQ_VALID_IN,
   input wire logic [shc_pkg::BANK_ADDR_W-1:0] REQ_CHAN_IN,
   input wire logic REQ_READY_OUT,
   input wire logic DONE_OUT,
   input wire shc_pkg::shc_pins_s PINS_OUT
);
   wire logic s = PINS_OUT.sample_hold_n;
   wire logic [6:0] a = {PINS_OUT.chip_choose, PINS_OUT.bank_addr_bit, PINS_OUT.host_addr_low};
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!NRST_IN);
   sequence s_take; REQ_VALID_IN && REQ_READY_OUT; endsequence
   property p_len; $fell(s) |-> ##40 $rose(s); endproperty
   a_len: assert property (p_len) else $error("sample width");
   property p_chg; !$stable(a) |-> s; endproperty
   a_chg: assert property (p_chg) else $error("address moved");
   property p_map; s_take |=> a == {$past(REQ_CHAN_IN[5]), $past(REQ_CHAN_IN)}; endproperty
   a_map: assert property (p_map) else $error("channel pins");
   property p_done; s_take |-> ##[46:47] DONE_OUT; endproperty
   a_done: assert property (p_done) else $error("done late");
   sequence s_addr_kept; $stable(a) ##1 $stable(a); endsequence
   property p_setup; $fell(s) |-> (a == $past(a, 1)) && (a == $past(a, 2)); endproperty
   a_setup: assert property (p_setup) else $error("address setup");
   property p_ahold; $rose(s) |=> s_addr_kept; endproperty
   a_ahold: assert property (p_ahold) else $error("address hold");
   property p_ready; s_take |=> !REQ_READY_OUT ##46 (REQ_READY_OUT && DONE_OUT); endproperty
   a_ready: assert property (p_ready) else $error("busy window");
endmodule : shc_ctrl_chk
bind shc_ctrl shc_ctrl_chk chk_i (.CLK_IN(CLK_IN), .NRST_IN(NRST_IN),
   .REQ_VALID_IN(REQ_VALID_IN), .REQ_CHAN_IN(REQ_CHAN_IN),
   .REQ_READY_OUT(REQ_READY_OUT), .DONE_OUT(DONE_OUT), .PINS_OUT(PINS_OUT));
`default_nettype wire

/* sim/shc_array_model.sv */
// Model of one 32-channel sample-and-hold array.
// Strap is board-tied per instance, not taken from the pins.
`timescale 1ns/100ps
`default_nettype none
module shc_array_model (
   input wire shc_pkg::shc_pins_s pins_in,
   input wire logic strap_in,
   output logic [31:0] channel_out
);
   always_comb channel_out = (!pins_in.sample_hold_n && pins_in.chip_choose != strap_in) ?
      32'h1 << pins_in.host_addr_low : 32'h0;
endmodule : shc_array_model
`default_nettype wire

/* sim/testbench.sv */
// Bench: sequencer driving two arrays as 64 channels.
// Standalone; refresh span cut to 200 cycles.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic CLK_IN, NRST_IN, REQ_VALID_IN, REQ_READY_OUT, DONE_OUT, REFRESH_DUE_OUT;
   logic [5:0] REQ_CHAN_IN;
   shc_pkg::shc_pins_s PINS_OUT;
   logic [31:0] lo_ch, hi_ch;
   int n_errors = 0;
   int cmp_count = 0;
   logic [5:0] tbl [5] = '{6'h00, 6'h1f, 6'h20, 6'h2a, 6'h3f};
   shc_ctrl #(.REFRESH_CYC(200)) shc_ctrl_i (.CLK_IN, .NRST_IN, .REQ_VALID_IN, .REQ_CHAN_IN,
      .REQ_READY_OUT, .DONE_OUT, .REFRESH_DUE_OUT, .PINS_OUT);
   shc_array_model shc_array_model_i (.pins_in(PINS_OUT), .strap_in(1'h1), .channel_out(lo_ch));
   shc_array_model shc_array_model_u_i (.pins_in(PINS_OUT), .strap_in(1'h0), .channel_out(hi_ch));
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("Error %0t: got %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic conclude();
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : conclude
   task automatic run_chan(input logic [5:0] ch);
      int k;
      int s0;
      int s1;
      int busy;
      k = 0;
      s0 = int'(shc_pkg::SETUP_CYC);
      s1 = s0 + int'(shc_pkg::SAMPLE_CYC);
      busy = s1 + int'(shc_pkg::AHOLD_CYC + shc_pkg::HOLD_PW_CYC);
      @(posedge CLK_IN);
      REQ_VALID_IN <= 1'h1;
      REQ_CHAN_IN <= ch;
      @(posedge CLK_IN);
      REQ_VALID_IN <= 1'h0;
      while (DONE_OUT !== 1'h1 && k < 60)
      begin
         @(posedge CLK_IN);
         #1;
         k++;
         check({hi_ch, lo_ch}, (k >= s0 && k < s1) ? 64'h1 << ch : 64'h0);
         check(REQ_READY_OUT, k >= busy);
      end
      check(k, busy);
   endtask : run_chan
   task automatic t_refresh();
      #1;
      check(PINS_OUT.sample_hold_n, shc_pkg::SH_HOLD);
      check(REQ_READY_OUT, 1'h1);
      check(REFRESH_DUE_OUT, 1'h0);
      repeat (205) @(posedge CLK_IN);
      #1;
      check(REFRESH_DUE_OUT, 1'h1);
   endtask : t_refresh
   task automatic t_reset_mid();
      // Reset lands mid-sample and must drop the line back to hold
      @(posedge CLK_IN);
      REQ_VALID_IN <= 1'h1;
      REQ_CHAN_IN <= 6'h25;
      @(posedge CLK_IN);
      REQ_VALID_IN <= 1'h0;
      repeat (10) @(posedge CLK_IN);
      #1;
      check({hi_ch, lo_ch}, 64'h1 << 37);
      @(posedge CLK_IN);
      NRST_IN <= 1'h0;
      repeat (2) @(posedge CLK_IN);
      NRST_IN <= 1'h1;
      #1;
      check(PINS_OUT.sample_hold_n, shc_pkg::SH_HOLD);
      check({hi_ch, lo_ch}, 64'h0);
      check(REQ_READY_OUT, 1'h1);
      check(REFRESH_DUE_OUT, 1'h0);
   endtask : t_reset_mid
   task automatic t_sweep();
      // Ends on channel 63 so the refresh flag must drop
      foreach (tbl[i]) run_chan(tbl[i]);
      repeat (3) @(posedge CLK_IN);
      #1;
      check(REFRESH_DUE_OUT, 1'h0);
   endtask : t_sweep
   initial
   begin
      CLK_IN = 1'h0;
      forever #50 CLK_IN = ~CLK_IN;
   end
   initial
   begin
      #200_000;
      n_errors++;
      conclude();
   end
   initial
   begin
      NRST_IN = 1'h0;
      REQ_VALID_IN = 1'h0;
      REQ_CHAN_IN = 6'h0;
      repeat (16) @(posedge CLK_IN);
      NRST_IN <= 1'h1;
      t_refresh();
      t_reset_mid();
      t_sweep();
      conclude();
   end
endmodule : testbench
`default_nettype wire
